// *** hw/mmp_memory_map.sv ***
`timescale 1ns/1ps
// Contract
// - Boot ROM of 8K answers code fetches at 0x0000 to 0x1FFF.
// - Fixed 8K code RAM at 0x2000 to 0x3FFF in every partition setting.
// - A fixed 8K RAM is sector FIFO, reached only by storage controller.
// - 4K endpoint buffer single-port RAM sits in data space E000 to EFFF.
// - Control registers and register buffers sit in data space F000 to F0F9.
// - Two-bit partition field assigns middle 24K RAM at 4000 to 9FFF.
// - Reset value 00 makes middle 24K code, code 2000-9FFF, FIFO 8K.
// - Value 01 gives code 2000-5FFF and a 24K sector FIFO.
// - Value 10 gives code 2000-3FFF and a 32K sector FIFO.
// - MCU writes partition field on any clock-enabled cycle; new map applies from the next cycle.
// - 1152 bytes internal data memory from address 0x00.
// - Endpoint buffer readable and writable by buffer manager and MCU.
// - Buffer manager reaches only the endpoint buffer and the endpoint descriptor registers.
module mmp_memory_map
	import mmp_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       clk_en_i,
	input  wire mmp_req_t   code_req_i,
	output mmp_rsp_t        code_rsp_o,
	input  wire mmp_req_t   xdata_req_i,
	output mmp_rsp_t        xdata_rsp_o,
	input  wire mmp_req_t   idata_req_i,
	output mmp_rsp_t        idata_rsp_o,
	input  wire mmp_req_t   ubm_req_i,
	output mmp_rsp_t        ubm_rsp_o,
	input  wire mmp_req_t   fifo_req_i,
	output mmp_rsp_t        fifo_rsp_o,
	output logic            reg_sel_o,
	output logic            reg_ubm_sel_o,
	output logic            reg_we_o,
	output logic [7:0]      reg_addr_o,
	output logic [7:0]      reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i,
	output logic [1:0]      ram_partition_select_o
);

	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	logic [7:0] boot_rom   [0:(1<<MMP_ROM_AW)-1];
	logic [7:0] code_ram   [0:(1<<MMP_CODE_AW)-1];
	logic [7:0] mid_ram    [0:(1<<MMP_MID_AW)-1];
	logic [7:0] fifo_ram   [0:(1<<MMP_FIFO_AW)-1];
	logic [7:0] epbuf_ram  [0:(1<<MMP_EPBUF_AW)-1];
	logic [7:0] idata_ram  [0:MMP_IDATA_LAST];

	// Boot image is loaded by the simulation or by the ROM generator; zero here.
	initial begin
		for (int i = 0; i < (1<<MMP_ROM_AW); i++) begin
			boot_rom[i] = 8'h00;
		end
	end

	logic [7:0] mode_q;
	logic [7:0] mode_d;
	mmp_part_t  part;
	logic [15:0] code_last;

	assign part = mmp_part_t'(mode_q[MMP_PART_LSB +: 2]);
	assign ram_partition_select_o = mode_q[MMP_PART_LSB +: 2];

	// Highest code address the MCU may reach for each partition setting.
	assign code_last = (part == MMP_PART_ALL_CODE) ? MMP_MID_LAST :
		(part == MMP_PART_HALF) ? MMP_MID01_LAST :
		MMP_FIXCODE_LAST;

	// Code space decode; the map follows the field combinationally.
	wire c_rom  = in_range(code_req_i.addr, MMP_ROM_BASE, MMP_ROM_LAST);
	wire c_fix  = in_range(code_req_i.addr, MMP_FIXCODE_BASE, MMP_FIXCODE_LAST);
	wire c_mid  = in_range(code_req_i.addr, MMP_MID_BASE, code_last);
	wire [MMP_MID_AW-1:0] c_mid_idx = MMP_MID_AW'(code_req_i.addr - MMP_MID_BASE);

	// Storage side: fixed 8K, then the middle RAM slice that code does not own.
	// The FIFO index grows upward from the code boundary so growth never aliases code.
	wire [15:0] fifo_mid_lim = 16'(MMP_MID_LAST - code_last);
	wire [15:0] fifo_off     = fifo_req_i.addr - 16'(1 << MMP_FIFO_AW);
	wire f_fix  = fifo_req_i.addr < 16'(1 << MMP_FIFO_AW);
	wire f_mid  = !f_fix && (fifo_off < fifo_mid_lim);
	wire [MMP_MID_AW-1:0] f_mid_idx =
		MMP_MID_AW'(code_last - MMP_MID_BASE + 16'h0001 + fifo_off);

	// Data space decode for the MCU.
	wire x_ep   = in_range(xdata_req_i.addr, MMP_EPBUF_BASE, MMP_EPBUF_LAST);
	wire x_reg  = in_range(xdata_req_i.addr, MMP_REG_BASE, MMP_REG_LAST);
	wire x_mode = xdata_req_i.addr == MMP_MODE_ADDR;

	// Buffer manager decode; it loses to the MCU on the single-port buffer.
	wire u_ep   = in_range(ubm_req_i.addr, MMP_EPBUF_BASE, MMP_EPBUF_LAST);
	wire u_edb  = in_range(ubm_req_i.addr, MMP_EDB_BASE, MMP_EDB_LAST);
	wire x_ep_go = xdata_req_i.req && x_ep;
	wire u_ep_go = ubm_req_i.req && u_ep && !x_ep_go;
	wire u_reg_go = ubm_req_i.req && u_edb && !(xdata_req_i.req && x_reg);
	wire x_reg_go = xdata_req_i.req && x_reg && !x_mode;

	wire i_ok = idata_req_i.addr <= {5'h00, MMP_IDATA_LAST};

	assign reg_sel_o     = x_reg_go || u_reg_go;
	assign reg_ubm_sel_o = u_reg_go;
	assign reg_we_o      = x_reg_go ? xdata_req_i.we : (u_reg_go && ubm_req_i.we);
	assign reg_addr_o    = x_reg_go ? xdata_req_i.addr[7:0] : ubm_req_i.addr[7:0];
	assign reg_wdata_o   = x_reg_go ? xdata_req_i.wdata : ubm_req_i.wdata;

	// Partition write takes effect on the next access.
	assign mode_d = (xdata_req_i.req && xdata_req_i.we && x_mode) ?
		xdata_req_i.wdata : mode_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= MMP_MODE_RESET;
		end else if (clk_en_i) begin
			mode_q <= mode_d;
		end
	end

	// Memory arrays: writes and registered read data.
	always_ff @(posedge core_clk_i) begin
		if (clk_en_i) begin
			if (code_req_i.req && code_req_i.we && c_fix) begin
				code_ram[code_req_i.addr[MMP_CODE_AW-1:0]] <= code_req_i.wdata;
			end
			if (code_req_i.req && code_req_i.we && c_mid) begin
				mid_ram[c_mid_idx] <= code_req_i.wdata;
			end
			if (fifo_req_i.req && fifo_req_i.we && f_fix) begin
				fifo_ram[fifo_req_i.addr[MMP_FIFO_AW-1:0]] <= fifo_req_i.wdata;
			end
			if (fifo_req_i.req && fifo_req_i.we && f_mid) begin
				mid_ram[f_mid_idx] <= fifo_req_i.wdata;
			end
			if (x_ep_go && xdata_req_i.we) begin
				epbuf_ram[xdata_req_i.addr[MMP_EPBUF_AW-1:0]] <= xdata_req_i.wdata;
			end else if (u_ep_go && ubm_req_i.we) begin
				epbuf_ram[ubm_req_i.addr[MMP_EPBUF_AW-1:0]] <= ubm_req_i.wdata;
			end
			if (idata_req_i.req && idata_req_i.we && i_ok) begin
				idata_ram[idata_req_i.addr[10:0]] <= idata_req_i.wdata;
			end
		end
	end

	// Read data selection, registered one cycle after the request.
	wire [7:0] c_rd = c_rom ? boot_rom[code_req_i.addr[MMP_ROM_AW-1:0]] :
		c_fix ? code_ram[code_req_i.addr[MMP_CODE_AW-1:0]] :
		c_mid ? mid_ram[c_mid_idx] : 8'h00;
	wire [7:0] f_rd = f_fix ? fifo_ram[fifo_req_i.addr[MMP_FIFO_AW-1:0]] :
		f_mid ? mid_ram[f_mid_idx] : 8'h00;
	wire [7:0] x_rd = x_ep ? epbuf_ram[xdata_req_i.addr[MMP_EPBUF_AW-1:0]] :
		x_mode ? mode_q : x_reg ? reg_rdata_i : 8'h00;
	wire [7:0] u_rd = u_ep ? epbuf_ram[ubm_req_i.addr[MMP_EPBUF_AW-1:0]] :
		u_edb ? reg_rdata_i : 8'h00;
	wire [7:0] i_rd = i_ok ? idata_ram[idata_req_i.addr[10:0]] : 8'h00;

	// A ROM write or a code access beyond the partition is flagged, never stored.
	wire c_err = !(c_rom && !code_req_i.we) && !c_fix && !c_mid;
	wire u_busy = (u_ep && x_ep_go) || (u_edb && xdata_req_i.req && x_reg);
	wire u_err = !u_ep && !u_edb;

	mmp_rsp_t code_d, fifo_d, x_d, u_d, i_d;
	assign code_d = '{valid: code_req_i.req, err: c_err, rdata: c_rd};
	assign fifo_d = '{valid: fifo_req_i.req, err: !f_fix && !f_mid, rdata: f_rd};
	assign x_d    = '{valid: xdata_req_i.req, err: !x_ep && !x_reg, rdata: x_rd};
	assign u_d    = '{valid: ubm_req_i.req && !u_busy, err: u_err, rdata: u_rd};
	assign i_d    = '{valid: idata_req_i.req, err: !i_ok, rdata: i_rd};

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			code_rsp_o  <= '0;
			fifo_rsp_o  <= '0;
			xdata_rsp_o <= '0;
			ubm_rsp_o   <= '0;
			idata_rsp_o <= '0;
		end else if (clk_en_i) begin
			code_rsp_o  <= code_d;
			fifo_rsp_o  <= fifo_d;
			xdata_rsp_o <= x_d;
			ubm_rsp_o   <= u_d;
			idata_rsp_o <= i_d;
		end
	end

endmodule

// *** hw/mmp_pkg.sv ***
package mmp_pkg;

	// Code space map.
	localparam logic [15:0] MMP_ROM_BASE     = 16'h0000;
	localparam logic [15:0] MMP_ROM_LAST     = 16'h1fff;
	localparam logic [15:0] MMP_FIXCODE_BASE = 16'h2000;
	localparam logic [15:0] MMP_FIXCODE_LAST = 16'h3fff;
	localparam logic [15:0] MMP_MID_BASE     = 16'h4000;
	localparam logic [15:0] MMP_MID01_LAST   = 16'h5fff;
	localparam logic [15:0] MMP_MID_LAST     = 16'h9fff;

	// External data space map.
	localparam logic [15:0] MMP_EPBUF_BASE = 16'he000;
	localparam logic [15:0] MMP_EPBUF_LAST = 16'hefff;
	localparam logic [15:0] MMP_REG_BASE   = 16'hf000;
	localparam logic [15:0] MMP_REG_LAST   = 16'hf0f9;

	// Endpoint descriptor block window inside register space (F000 to F07F).
	localparam logic [15:0] MMP_EDB_BASE = 16'hf000;
	localparam logic [15:0] MMP_EDB_LAST = 16'hf07f;

	// Internal data memory: 1152 bytes from 0x00.
	localparam logic [10:0] MMP_IDATA_LAST = 11'h47f;

	// Physical RAM sizes (address widths of the byte arrays).
	localparam int MMP_ROM_AW   = 13;
	localparam int MMP_CODE_AW  = 13;
	localparam int MMP_MID_AW   = 15;
	localparam int MMP_FIFO_AW  = 13;
	localparam int MMP_EPBUF_AW = 12;

	// Partition field layout in the mode configuration register.
	localparam int          MMP_PART_LSB   = 0;
	localparam logic [1:0]  MMP_PART_RESET = 2'h0;
	localparam logic [7:0]  MMP_MODE_RESET = 8'h00;
	localparam logic [15:0] MMP_MODE_ADDR  = 16'hf0f0;

	typedef enum logic [1:0] {
		MMP_PART_ALL_CODE = 2'b00,
		MMP_PART_HALF     = 2'b01,
		MMP_PART_ALL_FIFO = 2'b10,
		MMP_PART_RSVD     = 2'b11
	} mmp_part_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} mmp_req_t;

	typedef struct packed {
		logic       valid;
		logic       err;
		logic [7:0] rdata;
	} mmp_rsp_t;

endpackage

// *** testbench/mmp_memory_map_checker.sv ***
`timescale 1ns/1ps
module mmp_memory_map_checker
	import mmp_pkg::*;
(
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	input wire logic       clk_en_i,
	input wire mmp_req_t   code_req_i,
	input wire mmp_rsp_t   code_rsp_o,
	input wire mmp_req_t   xdata_req_i,
	input wire mmp_rsp_t   xdata_rsp_o,
	input wire mmp_req_t   idata_req_i,
	input wire mmp_rsp_t   idata_rsp_o,
	input wire mmp_req_t   ubm_req_i,
	input wire mmp_rsp_t   ubm_rsp_o,
	input wire mmp_req_t   fifo_req_i,
	input wire mmp_rsp_t   fifo_rsp_o,
	input wire logic       reg_sel_o,
	input wire logic [7:0] reg_addr_o,
	input wire logic [1:0] ram_partition_select_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [1:0]  pt = ram_partition_select_o;
	wire logic [15:0] ce = (pt == 2'h0) ? 16'h9fff : (pt == 2'h1) ? 16'h5fff : 16'h3fff;
	wire logic [15:0] fe = (pt == 2'h0) ? 16'h1fff : (pt == 2'h1) ? 16'h5fff : 16'h7fff;
	wire logic        cg = clk_en_i && code_req_i.req;
	wire logic        xg = clk_en_i && xdata_req_i.req;
	wire logic [15:0] xa = xdata_req_i.addr;
	a_code_limit_err: assert property (cg && code_req_i.addr > ce |=> code_rsp_o.err)
		else $error("code access past partition end accepted");
	a_rom_write_err: assert property (cg && code_req_i.we && code_req_i.addr < 16'h2000 |=> code_rsp_o.err)
		else $error("boot ROM write accepted");
	a_xdata_map_err: assert property (xg && (xa < 16'he000 || xa > 16'hf0f9) |=> xdata_rsp_o.err)
		else $error("unmapped data access accepted");
	a_idata_size_err: assert property (clk_en_i && idata_req_i.req && idata_req_i.addr > 16'h047f |=> idata_rsp_o.err)
		else $error("internal data access past end accepted");
	a_ubm_conflict_hold: assert property (xg && xa[15:12] == 4'he && ubm_req_i.req && ubm_req_i.addr[15:12] == 4'he |=> !ubm_rsp_o.valid)
		else $error("buffer manager served during conflict");
	a_reg_fwd_sel: assert property (xg && xa >= 16'hf000 && xa <= 16'hf0f9 && xa != MMP_MODE_ADDR |-> reg_sel_o && reg_addr_o == xa[7:0])
		else $error("register access not forwarded");
	a_part_write_now: assert property (xg && xdata_req_i.we && xa == MMP_MODE_ADDR |=> pt == $past(xdata_req_i.wdata[1:0]))
		else $error("partition write not applied");
	a_fifo_size_err: assert property (clk_en_i && fifo_req_i.req && fifo_req_i.addr > fe |=> fifo_rsp_o.err)
		else $error("sector FIFO access past size accepted");
	c_part_write: cover property (xg && xdata_req_i.we && xa == MMP_MODE_ADDR);
	c_fifo_top: cover property (fifo_req_i.req && fifo_req_i.addr == 16'h7fff && pt == 2'h2);
	c_conflict: cover property (xg && xa == 16'he000 && ubm_req_i.req);
endmodule

// *** testbench/mmp_memory_map_test.sv ***
`timescale 1ns/1ps
module mmp_memory_map_test
	import mmp_pkg::*;
;
	typedef struct {int p; logic we; logic [15:0] a; logic err;} mmp_row_t;
	logic       core_clk_i = 1'b0;
	logic       rst_n_i    = 1'b0;
	logic       reg_sel;
	logic [7:0] reg_addr;
	logic [7:0] reg_rdata;
	logic       reg_ubm_sel;
	logic       reg_we;
	logic [7:0] reg_wdata;
	logic       clk_en     = 1'b1;
	logic [1:0] part;
	mmp_req_t   rq [5] = '{default: '0};
	mmp_rsp_t   rs [5];
	mmp_rsp_t   r;
	int         n_errors = 0;
	int         num_checks = 0;
	mmp_row_t   rows [12] = '{'{0, 1'b0, 16'h1fff, 1'b0}, '{0, 1'b1, 16'h1000, 1'b1},
		'{0, 1'b0, 16'h9fff, 1'b0}, '{0, 1'b0, 16'ha000, 1'b1}, '{2, 1'b0, 16'h047f, 1'b0},
		'{2, 1'b0, 16'h0480, 1'b1}, '{1, 1'b0, 16'hdfff, 1'b1}, '{1, 1'b0, 16'hf0fa, 1'b1},
		'{4, 1'b0, 16'h1fff, 1'b0}, '{4, 1'b0, 16'h2000, 1'b1}, '{3, 1'b0, 16'hf080, 1'b1},
		'{3, 1'b0, 16'hf07f, 1'b0}};
	mmp_memory_map DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
		.code_req_i(rq[0]), .code_rsp_o(rs[0]), .xdata_req_i(rq[1]), .xdata_rsp_o(rs[1]),
		.idata_req_i(rq[2]), .idata_rsp_o(rs[2]), .ubm_req_i(rq[3]), .ubm_rsp_o(rs[3]),
		.fifo_req_i(rq[4]), .fifo_rsp_o(rs[4]), .reg_sel_o(reg_sel),
		.reg_ubm_sel_o(reg_ubm_sel), .reg_we_o(reg_we), .reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata),
		.ram_partition_select_o(part));
	mmp_reg_model regs (.core_clk_i(core_clk_i), .reg_sel_i(reg_sel), .reg_addr_i(reg_addr),
		.reg_rdata_o(reg_rdata));
	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// The answer stands for one cycle only, so it is captured just after the taking edge.
	task automatic acc(input int p, input logic we, input logic [15:0] a, input logic [7:0] d);
		rq[p] <= '{1'b1, we, a, d};
		@(posedge core_clk_i);
		rq[p] <= '0;
		#1 r = rs[p];
		chk("valid", {7'h0, r.valid}, 8'h01);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		chk("part_reset", {6'h0, part}, 8'h00);
		foreach (rows[i]) begin
			acc(rows[i].p, rows[i].we, rows[i].a, 8'h11);
			chk("row_err", {7'h0, r.err}, {7'h0, rows[i].err});
		end
		for (int k = 0; k < 4; k++) begin
			acc(1, 1'b1, MMP_MODE_ADDR, 8'(k));
			chk("part", {6'h0, part}, 8'(k));
			acc(0, 1'b0, 16'h5fff, 8'h00);
			chk("code_5fff", {7'h0, r.err}, {7'h0, k >= 2});
			acc(0, 1'b0, 16'h6000, 8'h00);
			chk("code_6000", {7'h0, r.err}, {7'h0, k != 0});
			acc(4, 1'b0, 16'h5fff, 8'h00);
			chk("fifo_5fff", {7'h0, r.err}, {7'h0, k == 0});
			acc(4, 1'b0, 16'h7fff, 8'h00);
			chk("fifo_7fff", {7'h0, r.err}, {7'h0, k < 2});
		end
		acc(0, 1'b1, 16'h2000, 8'h55);
		acc(0, 1'b0, 16'h2000, 8'h00);
		chk("code_ram", r.rdata, 8'h55);
		acc(2, 1'b1, 16'h0100, 8'h77);
		acc(2, 1'b0, 16'h0100, 8'h00);
		chk("idata_ram", r.rdata, 8'h77);
		acc(4, 1'b1, 16'h7000, 8'h99);
		acc(4, 1'b0, 16'h7000, 8'h00);
		chk("fifo_mid", r.rdata, 8'h99);
		acc(1, 1'b1, 16'he123, 8'h3c);
		acc(3, 1'b0, 16'he123, 8'h00);
		chk("epbuf_share", r.rdata, 8'h3c);
		acc(1, 1'b0, 16'hf005, 8'h00);
		chk("reg_mcu", r.rdata, 8'ha0);
		acc(3, 1'b0, 16'hf010, 8'h00);
		chk("reg_ubm", r.rdata, 8'hb5);
		rq[1] <= '{1'b1, 1'b0, 16'he000, 8'h00};
		rq[3] <= '{1'b1, 1'b1, 16'he000, 8'hee};
		@(posedge core_clk_i);
		rq[1] <= '0;
		rq[3] <= '0;
		#1 chk("ubm_refused", {7'h0, rs[3].valid}, 8'h00);
		rq[3] <= '{1'b1, 1'b1, 16'hf011, 8'h5a};
		#1 chk("reg_ubm_sel", {7'h0, reg_ubm_sel}, 8'h01);
		chk("reg_we", {7'h0, reg_we}, 8'h01);
		chk("reg_wdata", reg_wdata, 8'h5a);
		@(posedge core_clk_i);
		rq[3] <= '0;
		rst_n_i <= 1'b0;
		@(posedge core_clk_i);
		#1 chk("rst_part", {6'h0, part}, 8'h00);
		chk("rst_rsp", {7'h0, rs[0].valid}, 8'h00);
		@(posedge core_clk_i);
		rst_n_i <= 1'b1;
		clk_en <= 1'b0;
		rq[1] <= '{1'b1, 1'b1, MMP_MODE_ADDR, 8'h02};
		@(posedge core_clk_i);
		rq[1] <= '0;
		clk_en <= 1'b1;
		#1 chk("frozen_part", {6'h0, part}, 8'h00);
		chk("frozen_rsp", {7'h0, rs[1].valid}, 8'h00);
		results();
	end
endmodule
bind mmp_memory_map mmp_memory_map_checker chk_i (.*);

// *** testbench/mmp_reg_model.sv ***
`timescale 1ns/1ps
module mmp_reg_model (
	input  wire logic       core_clk_i,
	input  wire logic       reg_sel_i,
	input  wire logic [7:0] reg_addr_i,
	output logic [7:0]      reg_rdata_o
);
	logic [7:0] idle_q = 8'h3c;
	// When unselected the bus flips every cycle, so a stale byte never looks valid.
	always_ff @(posedge core_clk_i) begin
		idle_q <= ~idle_q;
	end
	assign reg_rdata_o = reg_sel_i ? (reg_addr_i ^ 8'ha5) : idle_q;
endmodule
